// file: pkg/line_supervisor_map.vh
/*
 * Constants for the line supervisor: timing figures and derived cycle counts.
 * Assumes a 25 MHz system clock; times are given in microseconds.
 */
`ifndef LINE_SUPERVISOR_MAP_VH
`define LINE_SUPERVISOR_MAP_VH

`define CLK_HZ              25000000
`define SAMPLE_PERIOD_US    1000
`define DROPOUT_TIME_US     60000
`define DETECT_TIME_US      32000
`define OFFMODE_ENTRY_US    50000
`define US_TO_CYC(us)       (((us) * (`CLK_HZ / 1000000)))
`define SAMPLE_CYCLES       `US_TO_CYC(`SAMPLE_PERIOD_US)
`define DROPOUT_CYCLES      `US_TO_CYC(`DROPOUT_TIME_US)
`define DETECT_CYCLES       `US_TO_CYC(`DETECT_TIME_US)
`define OFFMODE_CYCLES      `US_TO_CYC(`OFFMODE_ENTRY_US)

`endif

// file: verilog/line_supervisor.v
/*
 * Supervisory logic of an offline flyback controller: brown-out stop and
 * restart, ac-line unplug detection with capacitor discharge, and off mode.
 * Assumes analog comparators and the start-up current source sit outside;
 * all comparator decisions arrive asynchronously and are synchronised here.
 */
`timescale 1ns/1ns
`include "line_supervisor_map.vh"

module line_supervisor #(
	parameter SAMPLE_CYC  = `SAMPLE_CYCLES,   // sample-and-hold period
	parameter DROPOUT_CYC = `DROPOUT_CYCLES,  // line dropout timer
	parameter DETECT_CYC  = `DETECT_CYCLES,   // detection / discharge timer
	parameter OFFMODE_CYC = `OFFMODE_CYCLES   // off-mode entry timer
) (
	input  wire sys_clk,          // 25 MHz system clock
	input  wire rstn,             // Power-on reset, active low
	input  wire lineAboveStart,   // Line above start threshold
	input  wire lineAboveStop,    // Line above stop threshold
	input  wire lineAboveMin,     // Line above minimum threshold
	input  wire slopeCmp,         // Slope comparator output
	input  wire fbBelowOff,       // Feedback below 0.6 V
	input  wire fbAboveWake,      // Feedback above 2.2 V
	input  wire railAboveOn,      // Rail at turn-on level
	input  wire railBelowMin,     // Rail at minimum level
	input  wire railNearOff,      // Rail approaching turn-off level
	input  wire watchdogEvt,      // Watchdog event, one-cycle pulse
	input  wire thermalShutdown,  // Thermal shutdown active
	input  wire faultLatchIn,     // Latched fault request from protection
	input  wire faultClear,       // Latch release request (not in off mode)
	output reg  sampleHold,       // Sample strobe to the hold capacitor
	output reg  sourceOn,         // Start-up current source enable
	output reg  dischargeLevel,   // Source at discharge current
	output reg  switchEn,         // Permission to switch
	output reg  brownOut,         // Brown-out flag
	output reg  dcDetect,         // Line unplugged indication
	output reg  offMode,          // Low-consumption off mode
	output reg  faultLatched      // Stored latched fault
);

	// Main state machine, one-hot
	localparam [3:0] ST_OFF  = 4'h1;
	localparam [3:0] ST_WAIT = 4'h2;
	localparam [3:0] ST_RUN  = 4'h4;
	localparam [3:0] ST_BO   = 4'h8;

	localparam NSYNC = 11;

	// Terminal count of a timer.
	// One compare serves all four timers so their end points agree.
	// The limit is taken as a count of cycles, so a limit of N expires on the Nth cycle.
	function atLast;
		input [31:0] count;
		input [31:0] limit;
		begin
			atLast = (count == limit - 32'h1);
		end
	endfunction

	// Two-flop synchronisers for every async comparator input.
	// Comparators toggle with no regard to sys_clk, so nothing reads the first flop.
	// The stop comparator has its own pair so the dropout filter is easy to trace.
	// This costs two cycles of latency on every decision, far below any timer.
	wire [NSYNC-1:0] rawIn = {faultClear, faultLatchIn, thermalShutdown, railNearOff, railBelowMin,
		railAboveOn, fbAboveWake, fbBelowOff, slopeCmp, lineAboveMin, lineAboveStart};
	reg  [NSYNC-1:0] sync1_q;
	reg  [NSYNC-1:0] sync2_q;
	reg              stopSync1_q;
	reg              stopSync2_q;
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q     <= {NSYNC{1'b0}};
			sync2_q     <= {NSYNC{1'b0}};
			stopSync1_q <= 1'b0;
			stopSync2_q <= 1'b0;
		end else begin
			sync1_q     <= rawIn;
			sync2_q     <= sync1_q;
			stopSync1_q <= lineAboveStop;
			stopSync2_q <= stopSync1_q;
		end
	end

	wire sStart   = sync2_q[0];
	wire sMin     = sync2_q[1];
	wire sSlope   = sync2_q[2];
	wire sFbLow   = sync2_q[3];
	wire sFbWake  = sync2_q[4];
	wire sRailOn  = sync2_q[5];
	wire sRailMin = sync2_q[6];
	wire sRailOff = sync2_q[7];
	wire sTsd     = sync2_q[8];
	wire sFault   = sync2_q[9];
	wire sClear   = sync2_q[10];
	wire sStop    = stopSync2_q;

	// Sample-and-hold strobe; comparator offset and hold live in analog.
	// The strobe runs in every state, off mode included, since unplug sensing
	// depends on a fresh held sample each period.
	// Period accuracy sets the smallest slope that still counts as ac.
	reg [31:0] sampleCnt_q;
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sampleCnt_q <= 32'h0;
			sampleHold  <= 1'b0;
		end else if (atLast(sampleCnt_q, SAMPLE_CYC)) begin
			sampleCnt_q <= 32'h0;
			sampleHold  <= 1'b1;
		end else begin
			sampleCnt_q <= sampleCnt_q + 32'h1;
			sampleHold  <= 1'b0;
		end
	end

	// Edge detect on synchronised slope output (both directions).
	// Reset value matches the idle low of a dc line, so no false edge follows reset.
	// A steady low or steady high gives no edge and lets the timer run out.
	reg slopeLast_q;
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			slopeLast_q <= 1'b0;
		else
			slopeLast_q <= sSlope;
	end
	wire slopeEdge = sSlope ^ slopeLast_q;

	// Detection timer: restarted by edges, also bounds each discharge phase.
	// Runs in every state, so unplug is caught even in off mode.
	// Reusing one timer for detection and phase length keeps the draw duty at
	// one half, which bounds die heating whatever the filter capacitance.
	// Below the minimum line level the sequence ends; the line is already safe.
	reg [31:0] detCnt_q;
	reg        dischPhase_q;             // Discharge currently drawing
	wire       detExpire = atLast(detCnt_q, DETECT_CYC);
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			detCnt_q     <= 32'h0;
			dischPhase_q <= 1'b0;
			dcDetect     <= 1'b0;
		end else begin
			if (slopeEdge) begin
				detCnt_q <= 32'h0;
				dcDetect <= 1'b0;
				dischPhase_q <= 1'b0;
			end else if (dcDetect && !sMin) begin
				detCnt_q     <= 32'h0;
				dcDetect     <= 1'b0;
				dischPhase_q <= 1'b0;
			end else if (detExpire) begin
				detCnt_q <= 32'h0;
				dcDetect <= 1'b1;
				// Alternate draw and rest phases to limit die heating
				dischPhase_q <= ~dischPhase_q;
			end else begin
				detCnt_q <= detCnt_q + 32'h1;
			end
		end
	end

	// Dropout filter: stop only if line stays below stop threshold long enough.
	// The count saturates at expiry so the stop request stands until the line
	// returns; missing line cycles shorter than the timer leave switching alone.
	reg [31:0] dropCnt_q;
	wire       dropExpire = atLast(dropCnt_q, DROPOUT_CYC);
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			dropCnt_q <= 32'h0;
		else if (sStop || sStart)
			dropCnt_q <= 32'h0;
		else if (!dropExpire)
			dropCnt_q <= dropCnt_q + 32'h1;
	end

	// Off-mode entry qualifier; short feedback dips are filtered out.
	// Skip-mode ripple can dip the feedback briefly; any rise restarts the count.
	// The count saturates so a long low feedback keeps requesting entry.
	reg [31:0] offCnt_q;
	wire       offExpire = atLast(offCnt_q, OFFMODE_CYC);
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			offCnt_q <= 32'h0;
		else if (!sFbLow)
			offCnt_q <= 32'h0;
		else if (!offExpire)
			offCnt_q <= offCnt_q + 32'h1;
	end

	// Latched fault: survives off mode, cleared only outside it.
	// Remote shutdown through feedback must not be a way to unlatch a fault.
	// A set and a clear in one cycle leave the fault set.
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			faultLatched <= 1'b0;
		else if (sFault)
			faultLatched <= 1'b1;        // set wins over clear
		else if (sClear && !offMode)
			faultLatched <= 1'b0;
	end

	// Main state machine.
	// OFF is the start state and the thermal refuge; only a feedback wake leaves it.
	// BO waits for start permission: line above start, no watchdog block,
	// no discharge in progress and no latched fault.
	// WAIT holds permission until the rail reaches its turn-on level.
	// RUN is the only state that allows switching.
	// The watchdog block is set only by a dropout stop, to reject filter spikes.
	reg [3:0] state_q;
	reg [3:0] state_d;
	reg       wdBlock_q;                 // Restart blocked until watchdog
	reg       wdBlock_d;
	wire      startOk = sStart && !wdBlock_q && !dcDetect && !faultLatched;
	always @* begin
		state_d   = state_q;
		wdBlock_d = wdBlock_q;
		if (watchdogEvt)
			wdBlock_d = 1'b0;
		if (sTsd) begin
			state_d = ST_OFF;
		end else begin
			case (state_q)
				ST_OFF: begin
					if (sFbWake)
						state_d = ST_BO;
				end
				ST_BO: begin
					if (sFbLow && offExpire)
						state_d = ST_OFF;
					else if (startOk)
						state_d = ST_WAIT;
				end
				ST_WAIT: begin
					if (sFbLow && offExpire)
						state_d = ST_OFF;
					else if (!startOk)
						state_d = ST_BO;
					else if (sRailOn)
						state_d = ST_RUN;
				end
				ST_RUN: begin
					if (sFbLow && offExpire) begin
						state_d = ST_OFF;
					end else if (dropExpire) begin
						state_d   = ST_BO;
						wdBlock_d = 1'b1;
					end else if (dcDetect || faultLatched) begin
						state_d = ST_BO;
					end
				end
				default: state_d = ST_OFF;
			endcase
		end
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q   <= ST_OFF;
			wdBlock_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			wdBlock_q <= wdBlock_d;
		end
	end

	// Self-supply hysteresis: on at minimum level, off at turn-on level.
	// The near-off input forces the source on as a last guard for the rail.
	// The source cannot help with the line below minimum, so it is gated by it.
	reg supplyOn_q;
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			supplyOn_q <= 1'b0;
		else if (sRailMin || sRailOff)
			supplyOn_q <= 1'b1;
		else if (sRailOn)
			supplyOn_q <= 1'b0;
	end

	// Registered outputs; off mode drops everything but discharge and supply.
	// Switching is also cut by dc detection directly, so that it never
	// overlaps the first discharge cycle while the state catches up.
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sourceOn       <= 1'b0;
			dischargeLevel <= 1'b0;
			switchEn       <= 1'b0;
			brownOut       <= 1'b0;
			offMode        <= 1'b1;
		end else begin
			dischargeLevel <= dcDetect && dischPhase_q && sMin;
			sourceOn       <= (dcDetect && dischPhase_q && sMin) ||
				(supplyOn_q && sMin);
			switchEn       <= (state_q == ST_RUN) && !dcDetect;
			brownOut       <= (state_q == ST_BO) && !sStart;
			offMode        <= (state_q == ST_OFF);
		end
	end

endmodule // line_supervisor

// file: sim/line_supervisor_sva.sv
/* Port checker for the line supervisor.
   Assumes bind onto line_supervisor with sample period 8. */
`timescale 1ns/1ns
module line_supervisor_sva #(
	parameter DETECT_CYC  = 16, // detect period
	parameter OFFMODE_CYC = 12  // off entry time
) (
	input wire sys_clk,        // clock
	input wire rstn,           // reset
	input wire lineAboveMin,   // line min
	input wire slopeCmp,       // slope cmp
	input wire fbBelowOff,     // fb low
	input wire fbAboveWake,    // fb wake
	input wire thermalShutdown,// thermal
	input wire sampleHold,     // sample
	input wire sourceOn,       // source
	input wire dischargeLevel, // discharge
	input wire switchEn,       // switching
	input wire brownOut,       // brown-out
	input wire dcDetect,       // unplugged
	input wire offMode         // off mode
);
	reg [7:0] quietQ;
	reg [7:0] lowQ;
	reg       slopeQ;
	// Idle run since slope edge, feedback low run; both saturate
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			quietQ <= 8'h00;
			lowQ   <= 8'h00;
			slopeQ <= 1'b0;
		end else begin
			slopeQ <= slopeCmp;
			quietQ <= (slopeQ != slopeCmp) ? 8'h00 : quietQ + (quietQ != 8'hFF);
			lowQ   <= !fbBelowOff ? 8'h00 : lowQ + (lowQ != 8'hFF);
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	AST_SAMPLE: assert property (sampleHold |=> !sampleHold [*7] ##1 sampleHold)
		else $error("sample strobe period wrong");
	AST_OFF_SW: assert property (offMode |-> !switchEn) else $error("switching in off mode");
	AST_DIS_SW: assert property (dischargeLevel |-> !switchEn) else $error("start during discharge");
	AST_DIS_SRC: assert property (dischargeLevel |-> sourceOn) else $error("discharge without source");
	AST_BO_SW: assert property (brownOut |-> !switchEn) else $error("switching in brown-out");
	AST_DC_DIS: assert property ($rose(dcDetect) && lineAboveMin && $past(lineAboveMin, 3) |-> ##[0:2] dischargeLevel)
		else $error("no discharge");
	AST_DC_EDGE: assert property ($rose(dcDetect) |-> quietQ >= DETECT_CYC) else $error("dc too early");
	AST_MIN: assert property (!lineAboveMin [*6] |-> !dischargeLevel) else $error("discharge below min");
	AST_THERM: assert property (thermalShutdown |-> ##[1:6] offMode) else $error("thermal not off");
	AST_WAKE: assert property ($fell(offMode) |-> $past(fbAboveWake, 2)) else $error("woke without fb");
	AST_ENTRY: assert property ($rose(offMode) |-> lowQ >= OFFMODE_CYC || thermalShutdown)
		else $error("off entry too early");
	cover property ($rose(dcDetect));
	cover property ($fell(offMode));
	cover property ($rose(brownOut));
endmodule // line_supervisor_sva
bind line_supervisor line_supervisor_sva #(.DETECT_CYC(DETECT_CYC), .OFFMODE_CYC(OFFMODE_CYC)) i_sva (.*);

// file: sim/analog_front_model.sv
/* Far-side model: slope comparator and supply rail.
   Assumes the bench sets acOn; rail follows sourceOn. */
`timescale 1ns/1ns
module analog_front_model (
	input  wire sys_clk,      // clock
	input  wire acOn,         // ac present
	input  wire sourceOn,     // source enable
	output reg  slopeCmp,     // slope cmp
	output wire railAboveOn,  // rail on level
	output wire railBelowMin, // rail min
	output wire railNearOff   // rail near off
);
	reg [3:0] phaseQ = 4'h0;
	reg [4:0] railQ  = 5'h0A;
	// Pulses only on rising line; dc holds low, never toggles
	always @(posedge sys_clk) begin
		phaseQ   <= phaseQ + 4'h1;
		slopeCmp <= acOn & phaseQ[1];
	end
	// Rail charges on source and sags otherwise
	always @(posedge sys_clk) begin
		if (sourceOn && railQ != 5'h1F)
			railQ <= railQ + 5'h01;
		else if (!sourceOn && railQ != 5'h04)
			railQ <= railQ - 5'h01;
	end
	assign railAboveOn  = railQ >= 5'h18;
	assign railBelowMin = railQ <= 5'h08;
	assign railNearOff  = railQ <= 5'h05;
endmodule // analog_front_model

// file: sim/testbench.sv
/* Self-checking bench for the line supervisor.
   Assumes the analog model drives slope and rail inputs. */
`timescale 1ns/1ns
module testbench;
	localparam DROPC = 20, DETC = 16, OFFC = 12;
	reg sys_clk = 0, rstn, lineAboveStart, lineAboveStop, lineAboveMin, acOn;
	reg fbBelowOff, fbAboveWake, watchdogEvt, thermalShutdown, faultLatchIn, faultClear;
	wire slopeCmp, railAboveOn, railBelowMin, railNearOff;
	wire sampleHold, sourceOn, dischargeLevel, switchEn, brownOut, dcDetect, offMode, faultLatched;
	integer fails = 0, n_compared = 0, cyc = 0, i, len, seed = 76157;
	line_supervisor #(.SAMPLE_CYC(8), .DROPOUT_CYC(DROPC), .DETECT_CYC(DETC), .OFFMODE_CYC(OFFC))
		i_line_supervisor (.*);
	analog_front_model i_analog_front_model (.*);
	// Clock and hang guard
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			report_and_stop;
		end
	end
	function logic sel(input integer k);
		case (k)
			0: sel = offMode;
			1: sel = switchEn;
			2: sel = brownOut;
			3: sel = dcDetect;
			4: sel = dischargeLevel;
			default: sel = faultLatched;
		endcase
	endfunction
	function logic dipEnters(input integer n);
		dipEnters = n >= OFFC;
	endfunction
	task check(input logic got, input logic exp, input string msg);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	// Bounded wait, sampled at the falling edge
	task waitSig(input integer k, input logic v, input integer maxc, input string msg);
		integer j;
		for (j = 0; j < maxc && sel(k) !== v; j++) @(negedge sys_clk);
		check(sel(k), v, msg);
	endtask
	task setLine(input logic v);
		@(posedge sys_clk);
		lineAboveStart <= v;
		lineAboveStop  <= v;
	endtask
	task wake;
		@(posedge sys_clk);
		fbAboveWake <= 1'b1;
		waitSig(0, 1'b0, 10, "wake");
		@(posedge sys_clk);
		fbAboveWake <= 1'b0;
	endtask
	task report_and_stop;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		{lineAboveStart, lineAboveStop, lineAboveMin, acOn, rstn} = 5'h1E;
		{fbBelowOff, fbAboveWake, watchdogEvt, thermalShutdown, faultLatchIn, faultClear} = 6'h00;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(negedge sys_clk);
		check(offMode, 1'b1, "initial off");
		wake;
		waitSig(1, 1'b1, 300, "start");
		for (i = 0; i < 6; i++) begin
			len = 1 + {$random(seed)} % (OFFC - 4);
			@(posedge sys_clk);
			fbBelowOff <= 1'b1;
			repeat (len) @(posedge sys_clk);
			fbBelowOff <= 1'b0;
			repeat (20) @(negedge sys_clk);
			check(offMode, dipEnters(len), "short dip");
		end
		$display("test wake and dips done");
		setLine(0);
		repeat (DROPC / 2) @(posedge sys_clk);
		setLine(1);
		repeat (10) @(negedge sys_clk);
		check(switchEn, 1'b1, "short dropout");
		setLine(0);
		waitSig(2, 1'b1, DROPC + 10, "brown-out");
		check(switchEn, 1'b0, "halted");
		setLine(1);
		repeat (60) @(negedge sys_clk);
		check(switchEn, 1'b0, "restart blocked");
		@(posedge sys_clk);
		watchdogEvt <= 1'b1;
		@(posedge sys_clk);
		watchdogEvt <= 1'b0;
		waitSig(1, 1'b1, 300, "restart");
		@(posedge sys_clk);
		thermalShutdown <= 1'b1;
		waitSig(0, 1'b1, 10, "thermal");
		@(posedge sys_clk);
		thermalShutdown <= 1'b0;
		$display("test dropout and thermal done");
		wake;
		faultLatchIn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		faultLatchIn <= 1'b0;
		waitSig(5, 1'b1, 10, "fault set");
		fbBelowOff <= 1'b1;
		waitSig(0, 1'b1, OFFC + 10, "off entry");
		check(switchEn, 1'b0, "off quiet");
		fbBelowOff <= 1'b0;
		faultClear <= 1'b1;
		repeat (8) @(negedge sys_clk);
		check(faultLatched, 1'b1, "fault kept");
		@(posedge sys_clk);
		faultClear <= 1'b0;
		acOn <= 1'b0;
		waitSig(3, 1'b1, DETC + 20, "dc detect");
		waitSig(4, 1'b1, 4, "discharge");
		check(switchEn, 1'b0, "start inhibited");
		@(posedge sys_clk);
		acOn <= 1'b1;
		waitSig(3, 1'b0, DETC + 20, "ac back");
		waitSig(4, 1'b0, 4, "discharge ends");
		@(posedge sys_clk);
		acOn <= 1'b0;
		waitSig(3, 1'b1, DETC + 20, "dc again");
		waitSig(4, 1'b1, 4, "discharge again");
		@(posedge sys_clk);
		lineAboveMin <= 1'b0;
		waitSig(4, 1'b0, 10, "below minimum");
		waitSig(3, 1'b0, 4, "dc ends below minimum");
		@(posedge sys_clk);
		lineAboveMin <= 1'b1;
		acOn <= 1'b1;
		wake;
		faultClear <= 1'b1;
		waitSig(5, 1'b0, 10, "fault cleared outside off");
		@(posedge sys_clk);
		faultClear <= 1'b0;
		$display("test off mode and unplug done");
		report_and_stop;
	end
endmodule // testbench
